/* cam_link_model.sv */
// Far-side model: free-running pixel ticks, sensor event pulses, CC lines.
// Assumes fire_i bits are one-cycle requests from the bench on mclk_i.
`timescale 1ns/1ps
module cam_link_model #(
	parameter int PIX_DIV = 4
)
(
	// Clock and requests
	input  wire logic       mclk_i,
	input  wire logic [4:0] fire_i,
	// Link side
	output logic            pix_tick_o,
	output logic [2:0]      pulse_o = 3'h0,
	output logic [1:0]      cc_o
);
	logic [7:0] div_q = 8'h00;
	logic [2:0] cc2_q = 3'h0;
	logic [2:0] cc3_q = 3'h0;
	// Free-running, so rounding is seen at any phase
	// Plain always: these variables start from declaration values, no reset pin
	always @(posedge mclk_i)
	begin
		div_q <= (div_q == 8'(PIX_DIV - 1)) ? 8'h00 : div_q + 8'h01;
	end
	always @(posedge mclk_i)
	begin
		pulse_o <= fire_i[2:0];
	end
	// CC levels stay up a while; only the rise is an event
	always @(posedge mclk_i)
	begin
		cc2_q <= fire_i[3] ? 3'h3 : cc2_q - 3'(cc2_q != 3'h0);
		cc3_q <= fire_i[4] ? 3'h3 : cc3_q - 3'(cc3_q != 3'h0);
	end
	assign pix_tick_o = (div_q == 8'h00);
	assign cc_o = {cc3_q != 3'h0, cc2_q != 3'h0};
endmodule

/* camera_profile_event_control.sv */
// APB register bank, switchport generators and working-parameter events
// of the camera profile logic. Assumes pixel ticks, integration events and
// camera-control lines arrive synchronous to mclk_i.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "camera_profile_params.svh"

module camera_profile_event_control
	import camera_profile_pkg::*;
#(
	parameter logic [31:0] FIRMWARE_REVISION = 32'h0000_0100 // Arbitrary value
)
(
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [13:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Sensor and link events
	input  wire logic        pix_tick_i,
	input  wire logic        trigger_evt_i,
	input  wire logic        integ_begin_i,
	input  wire logic        integ_end_i,
	input  wire logic        cc2_i,
	input  wire logic        cc3_i,
	input  wire logic [7:0]  capture_trigger_origin_i,
	input  wire logic [15:0] temp_sensor_i,
	input  wire logic [15:0] temp_housing_i,
	// Switchport pins
	output logic      [1:0]  switchport_o,
	// Sensor control
	output logic             sensor_trigger_start_o,
	output logic      [2:0]  exposure_sections_o,
	output logic             rolling_shutter_o,
	output calib_ctl_s       calib_ctl_o,
	output logic             column_charge_continuous_o,
	output profile_cmd_s     profile_init_o,
	output profile_cmd_s     profile_copy_o
);

	function automatic logic hit(input logic [11:0] idx, input logic [11:0] base);
		hit = (idx == base);
	endfunction

	function automatic logic [31:0] wide(input logic [15:0] v);
		wide = {16'h0000, v};
	endfunction

	logic [11:0] idx;
	logic        wr_en;
	logic        rd_en;
	logic        mapped;

	logic [31:0] pixel_rate_hz_q;
	sw_cfg_s     sw_cfg_q [2];
	logic [15:0] roi_column_origin_q;
	logic [15:0] roi_line_origin_q;
	logic [15:0] roi_pixel_width_q;
	logic [15:0] roi_line_height_q;
	logic [31:0] exposure_q [4];
	logic [7:0]  shutter_principle_q;
	logic [7:0]  line_column_skipping_q;
	logic [7:0]  analog_gain_select_q;
	logic [7:0]  amp_calibration_mode_q;
	logic [7:0]  column_charge_mode_q;
	logic [31:0] label_q [8];

	logic [2:0]  soft_evt_q;
	logic [1:0]  cc_prev_q;
	logic [1:0]  fire;
	sp_state_e   sp_state_q [2];
	logic [31:0] sp_ns_q [2];
	logic        rolling;

	// Registers decode on the word index; byte lanes are not used
	assign idx      = paddr_i[13:2];
	assign wr_en    = psel_i & penable_i & pwrite_i;
	assign rd_en    = psel_i & penable_i & ~pwrite_i;
	assign pready_o = 1'b1;
	assign rolling  = (shutter_principle_q == `SHUTTER_ROLLING);

	always_comb
	begin
		mapped = 1'b0;
		if (hit(idx, `IDX_PIXEL_RATE) || hit(idx, `IDX_SW0_SOURCE) ||
			hit(idx, `IDX_SW0_POLARITY) || hit(idx, `IDX_SW0_DELAY) ||
			hit(idx, `IDX_SW0_LENGTH) || hit(idx, `IDX_SW1_SOURCE) ||
			hit(idx, `IDX_SW1_POLARITY) || hit(idx, `IDX_SW1_DELAY) ||
			hit(idx, `IDX_SW1_LENGTH) || hit(idx, `IDX_ROI_COL) ||
			hit(idx, `IDX_ROI_LINE) || hit(idx, `IDX_ROI_WIDTH) ||
			hit(idx, `IDX_ROI_HEIGHT) || hit(idx, `IDX_SHUTTER) ||
			hit(idx, `IDX_SKIPPING) || hit(idx, `IDX_GAIN) ||
			hit(idx, `IDX_CALIB) || hit(idx, `IDX_CHARGE) ||
			hit(idx, `IDX_VERSION) || hit(idx, `IDX_EVENT) ||
			hit(idx, `IDX_INIT) || hit(idx, `IDX_COPY) ||
			hit(idx, `IDX_TEMP0) || hit(idx, `IDX_TEMP1))
			mapped = 1'b1;
		for (int k = 0; k < 4; k++)
			if (hit(idx, 12'(`IDX_EXPOSURE0 + k * `IDX_EXPOSURE_STEP)))
				mapped = 1'b1;
		for (int k = 0; k < 8; k++)
			if (hit(idx, 12'(`IDX_LABEL0 + k * `IDX_LABEL_STEP)))
				mapped = 1'b1;
	end

	assign pslverr_o = psel_i & penable_i & ~mapped;

	// Reads of write-only locations give zero
	always_comb
	begin
		prdata_o = 32'h0000_0000;
		if (rd_en)
		begin
			case (idx)
				`IDX_PIXEL_RATE:   prdata_o = pixel_rate_hz_q;
				`IDX_SW0_SOURCE:   prdata_o = {24'h000000, sw_cfg_q[0].source};
				`IDX_SW0_POLARITY: prdata_o = {24'h000000, sw_cfg_q[0].polarity};
				`IDX_SW0_DELAY:    prdata_o = sw_cfg_q[0].delay_ns;
				`IDX_SW0_LENGTH:   prdata_o = sw_cfg_q[0].length_ns;
				`IDX_SW1_SOURCE:   prdata_o = {24'h000000, sw_cfg_q[1].source};
				`IDX_SW1_POLARITY: prdata_o = {24'h000000, sw_cfg_q[1].polarity};
				`IDX_SW1_DELAY:    prdata_o = sw_cfg_q[1].delay_ns;
				`IDX_SW1_LENGTH:   prdata_o = sw_cfg_q[1].length_ns;
				`IDX_ROI_COL:      prdata_o = wide(roi_column_origin_q);
				`IDX_ROI_LINE:     prdata_o = wide(roi_line_origin_q);
				`IDX_ROI_WIDTH:    prdata_o = wide(roi_pixel_width_q);
				`IDX_ROI_HEIGHT:   prdata_o = wide(roi_line_height_q);
				`IDX_SHUTTER:      prdata_o = {24'h000000, shutter_principle_q};
				`IDX_SKIPPING:     prdata_o = {24'h000000, line_column_skipping_q};
				`IDX_GAIN:         prdata_o = {24'h000000, analog_gain_select_q};
				`IDX_CALIB:        prdata_o = {24'h000000, amp_calibration_mode_q};
				`IDX_CHARGE:       prdata_o = {24'h000000, column_charge_mode_q};
				`IDX_VERSION:      prdata_o = FIRMWARE_REVISION;
				`IDX_TEMP0:        prdata_o = wide(temp_sensor_i);
				`IDX_TEMP1:        prdata_o = wide(temp_housing_i);
				default:           prdata_o = 32'h0000_0000;
			endcase
			for (int k = 0; k < 4; k++)
				if (hit(idx, 12'(`IDX_EXPOSURE0 + k * `IDX_EXPOSURE_STEP)))
					prdata_o = exposure_q[k];
			for (int k = 0; k < 8; k++)
				if (hit(idx, 12'(`IDX_LABEL0 + k * `IDX_LABEL_STEP)))
					prdata_o = label_q[k];
		end
	end

	// Profile registers; all contents are lost on reset
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			pixel_rate_hz_q        <= `RST_PIXEL_RATE;
			for (int k = 0; k < 2; k++)
			begin
				sw_cfg_q[k].source    <= `RST_SW_SOURCE;
				sw_cfg_q[k].polarity  <= `RST_SW_POLARITY;
				sw_cfg_q[k].delay_ns  <= `RST_SW_DELAY;
				sw_cfg_q[k].length_ns <= `RST_SW_LENGTH;
			end
			roi_column_origin_q    <= `RST_ROI_COL;
			roi_line_origin_q      <= `RST_ROI_LINE;
			roi_pixel_width_q      <= `RST_ROI_WIDTH;
			roi_line_height_q      <= `RST_ROI_HEIGHT;
			for (int k = 0; k < 3; k++)
				exposure_q[k] <= `RST_EXPOSURE_LOW;
			exposure_q[3]          <= `RST_EXPOSURE_LAST;
			shutter_principle_q    <= `RST_BYTE_ZERO;
			line_column_skipping_q <= `RST_BYTE_ZERO;
			analog_gain_select_q   <= `RST_BYTE_ZERO;
			amp_calibration_mode_q <= `RST_BYTE_ZERO;
			column_charge_mode_q   <= `RST_BYTE_ZERO;
			for (int k = 0; k < 8; k++)
				label_q[k] <= 32'h0000_0000;
		end
		else if (wr_en)
		begin
			// ROI limits are software's to respect; stored as written
			case (idx)
				`IDX_PIXEL_RATE:   pixel_rate_hz_q          <= pwdata_i;
				`IDX_SW0_SOURCE:   sw_cfg_q[0].source       <= pwdata_i[7:0];
				`IDX_SW0_POLARITY: sw_cfg_q[0].polarity     <= pwdata_i[7:0];
				`IDX_SW0_DELAY:    sw_cfg_q[0].delay_ns     <= pwdata_i;
				`IDX_SW0_LENGTH:   sw_cfg_q[0].length_ns    <= pwdata_i;
				`IDX_SW1_SOURCE:   sw_cfg_q[1].source       <= pwdata_i[7:0];
				`IDX_SW1_POLARITY: sw_cfg_q[1].polarity     <= pwdata_i[7:0];
				`IDX_SW1_DELAY:    sw_cfg_q[1].delay_ns     <= pwdata_i;
				`IDX_SW1_LENGTH:   sw_cfg_q[1].length_ns    <= pwdata_i;
				`IDX_ROI_COL:      roi_column_origin_q      <= pwdata_i[15:0];
				`IDX_ROI_LINE:     roi_line_origin_q        <= pwdata_i[15:0];
				`IDX_ROI_WIDTH:    roi_pixel_width_q        <= pwdata_i[15:0];
				`IDX_ROI_HEIGHT:   roi_line_height_q        <= pwdata_i[15:0];
				`IDX_SHUTTER:      shutter_principle_q      <= pwdata_i[7:0];
				`IDX_SKIPPING:     line_column_skipping_q   <= pwdata_i[7:0];
				`IDX_GAIN:         analog_gain_select_q     <= pwdata_i[7:0];
				`IDX_CALIB:        amp_calibration_mode_q   <= pwdata_i[7:0];
				`IDX_CHARGE:       column_charge_mode_q     <= pwdata_i[7:0];
				default:           ;
			endcase
			for (int k = 0; k < 4; k++)
				if (hit(idx, 12'(`IDX_EXPOSURE0 + k * `IDX_EXPOSURE_STEP)))
					exposure_q[k] <= pwdata_i;
			for (int k = 0; k < 8; k++)
				if (hit(idx, 12'(`IDX_LABEL0 + k * `IDX_LABEL_STEP)))
					label_q[k] <= pwdata_i;
		end
	end

	// Event register: one-cycle pulses, nothing stored
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
			soft_evt_q <= 3'b000;
		else if (wr_en && hit(idx, `IDX_EVENT))
			soft_evt_q <= pwdata_i[2:0];
		else
			soft_evt_q <= 3'b000;
	end

	// Soft trigger only reaches the generator if it is the chosen source
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
			sensor_trigger_start_o <= 1'b0;
		else
			sensor_trigger_start_o <= soft_evt_q[`EVT_BIT_TRIGGER] &&
				(capture_trigger_origin_i == `TRIG_SRC_EVENT_REG);
	end

	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			profile_init_o <= '0;
			profile_copy_o <= '0;
		end
		else
		begin
			profile_init_o.valid <= wr_en && hit(idx, `IDX_INIT);
			profile_init_o.code  <= pwdata_i[7:0];
			profile_copy_o.valid <= wr_en && hit(idx, `IDX_COPY);
			profile_copy_o.code  <= pwdata_i[7:0];
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
			cc_prev_q <= 2'b00;
		else
			cc_prev_q <= {cc3_i, cc2_i};
	end

	// Source select per switchport
	always_comb
	begin
		for (int k = 0; k < 2; k++)
		begin
			case (sw_cfg_q[k].source)
				SRC_TRIGGER: fire[k] = trigger_evt_i;
				SRC_BEGIN:   fire[k] = integ_begin_i & ~rolling;
				SRC_END:     fire[k] = integ_end_i & ~rolling;
				SRC_CC2:     fire[k] = cc2_i & ~cc_prev_q[0];
				SRC_CC3:     fire[k] = cc3_i & ~cc_prev_q[1];
				SRC_EVENT:   fire[k] = soft_evt_q[`EVT_BIT_SW0 + k];
				default:     fire[k] = 1'b0;
			endcase
		end
	end

	// Time runs in ns at mclk rate but steps only on pixel ticks,
	// so delay and length round up to whole pixel periods.
	// A new event while busy is dropped rather than queued.
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			for (int k = 0; k < 2; k++)
			begin
				sp_state_q[k] <= SP_IDLE;
				sp_ns_q[k]    <= 32'h0000_0000;
			end
		end
		else
		begin
			for (int k = 0; k < 2; k++)
			begin
				case (sp_state_q[k])
					SP_IDLE:
					begin
						sp_ns_q[k] <= 32'h0000_0000;
						if (fire[k])
							sp_state_q[k] <= SP_DELAY;
					end
					SP_DELAY:
					begin
						sp_ns_q[k] <= sp_ns_q[k] + `MCLK_PERIOD_NS;
						if (pix_tick_i && sp_ns_q[k] >= sw_cfg_q[k].delay_ns)
						begin
							sp_state_q[k] <= SP_PULSE;
							sp_ns_q[k]    <= 32'h0000_0000;
						end
					end
					SP_PULSE:
					begin
						sp_ns_q[k] <= sp_ns_q[k] + `MCLK_PERIOD_NS;
						if (pix_tick_i && sp_ns_q[k] >= sw_cfg_q[k].length_ns)
							sp_state_q[k] <= SP_IDLE;
					end
					default:
						sp_state_q[k] <= SP_IDLE;
				endcase
				if (sw_cfg_q[k].source == SRC_OFF)
					sp_state_q[k] <= SP_IDLE;
			end
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
			switchport_o <= 2'b00;
		else
			for (int k = 0; k < 2; k++)
				if (sw_cfg_q[k].source == SRC_OFF)
					switchport_o[k] <= |sw_cfg_q[k].polarity;
				else
					switchport_o[k] <= (sp_state_q[k] == SP_PULSE) ~^
						(|sw_cfg_q[k].polarity);
	end

	// Sensor mode outputs
	always_ff @(posedge mclk_i)
	begin
		if (!nrst_i)
		begin
			exposure_sections_o        <= 3'd0;
			rolling_shutter_o          <= 1'b0;
			calib_ctl_o                <= '0;
			column_charge_continuous_o <= 1'b0;
		end
		else
		begin
			exposure_sections_o <= rolling ? 3'd0 :
				3'(exposure_q[0] != 0) + 3'(exposure_q[1] != 0) +
				3'(exposure_q[2] != 0) + 3'(exposure_q[3] != 0);
			rolling_shutter_o   <= rolling;
			calib_ctl_o.fast         <= (amp_calibration_mode_q == 8'h00);
			calib_ctl_o.image_start  <= (amp_calibration_mode_q == 8'h01) ||
				(amp_calibration_mode_q == 8'h03);
			calib_ctl_o.line_pending <= (amp_calibration_mode_q == 8'h02) ||
				(amp_calibration_mode_q == 8'h03);
			column_charge_continuous_o <=
				(column_charge_mode_q == `CHARGE_CONTINUOUS);
		end
	end

endmodule

/* camera_profile_event_control_asserts.sv */
// Port checker for the camera profile block.
// Assumes one clock domain and APB byte address = 4 * index.
`timescale 1ns/1ps
`include "camera_profile_params.svh"
module cpec_checker
	import camera_profile_pkg::*;
(
	input wire logic        mclk_i,
	input wire logic        nrst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [13:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic [7:0]  capture_trigger_origin_i,
	input wire logic        sensor_trigger_start_o,
	input wire logic [2:0]  exposure_sections_o,
	input wire logic        rolling_shutter_o,
	input calib_ctl_s       calib_ctl_o,
	input wire logic        column_charge_continuous_o
);
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!nrst_i);
	logic        wr_acc;
	logic [11:0] idx;
	logic        trig_cause;
	assign wr_acc = psel_i && penable_i && pwrite_i;
	assign idx = paddr_i[13:2];
	// Origin must name the event register, else the write is inert
	assign trig_cause = wr_acc && idx == `IDX_EVENT && pwdata_i[0]
		&& capture_trigger_origin_i == `TRIG_SRC_EVENT_REG;
	a_event_trigger: assert property (
		trig_cause |-> ##2 sensor_trigger_start_o) else $error("trigger pulse missing");
	a_trigger_cause: assert property (
		sensor_trigger_start_o |-> $past(trig_cause, 2)) else $error("trigger without cause");
	a_trigger_single: assert property (
		sensor_trigger_start_o |=> !sensor_trigger_start_o) else $error("trigger too long");
	a_wo_read_zero: assert property (
		psel_i && penable_i && !pwrite_i && idx inside {12'h904, 12'h905, 12'h906}
		|-> prdata_o == 32'h0) else $error("write-only read not zero");
	a_rolling_sections: assert property (
		rolling_shutter_o |-> exposure_sections_o == 3'h0) else $error("sections in rolling");
	a_shutter_write: assert property (
		wr_acc && idx == `IDX_SHUTTER && pwdata_i[7:0] == 8'h01
		|-> ##[1:2] rolling_shutter_o) else $error("rolling flag not set");
	a_calib_fast: assert property (
		wr_acc && idx == `IDX_CALIB && pwdata_i[7:0] == 8'h00
		|-> ##[1:2] calib_ctl_o == 3'b100) else $error("fast calibration wrong");
	a_calib_both: assert property (
		wr_acc && idx == `IDX_CALIB && pwdata_i[7:0] == 8'h03
		|-> ##[1:2] calib_ctl_o == 3'b011) else $error("slow calibration wrong");
	a_charge_write: assert property (
		wr_acc && idx == `IDX_CHARGE && pwdata_i[7:0] == 8'h01
		|-> ##[1:2] column_charge_continuous_o) else $error("charge mode not set");
endmodule

bind camera_profile_event_control cpec_checker u_chk (.mclk_i, .nrst_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .capture_trigger_origin_i,
	.sensor_trigger_start_o, .exposure_sections_o, .rolling_shutter_o, .calib_ctl_o,
	.column_charge_continuous_o);

/* camera_profile_event_control_tb.sv */
// Self-checking bench for the camera profile block.
// Assumes zero-wait APB and a 20 ns pixel tick from the link model.
`timescale 1ns/1ps
`include "camera_profile_params.svh"
module camera_profile_event_control_tb;
	logic        mclk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [13:0] paddr_i = 14'h0000;
	logic [31:0] pwdata_i = 32'h0;
	logic [7:0]  origin = 8'h00;
	logic [4:0]  fire_q = 5'h00;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic        pix_tick;
	logic [2:0]  pulse;
	logic [1:0]  cc;
	logic [1:0]  switchport_o;
	logic        trig_o;
	logic [2:0]  sections;
	logic        rolling;
	logic [2:0]  calib;
	logic        charge;
	logic [8:0]  init_cmd;
	logic [8:0]  copy_cmd;
	int          err_total = 0;
	int          tests_run = 0;
	logic [31:0] rd;
	logic        err;
	int          dly;
	int          wid;
	int          hi;
	localparam logic [11:0] RIDX [8] = '{12'h10e, 12'h10f, 12'h11e, 12'h134, 12'h136,
		12'h138, 12'h144, 12'h102};
	localparam logic [31:0] RVAL [8] = '{32'h0, 32'h1, 32'h3e8, 32'h4fe, 32'h3ff, 32'h0,
		32'h015eef80, 32'h02625a00};
	localparam logic [31:0] CAL [4] = '{32'h4, 32'h2, 32'h1, 32'h3};

	always #2.5 mclk_i = ~mclk_i;

	camera_profile_event_control uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.pix_tick_i(pix_tick), .trigger_evt_i(pulse[0]), .integ_begin_i(pulse[1]),
		.integ_end_i(pulse[2]), .cc2_i(cc[0]), .cc3_i(cc[1]),
		.capture_trigger_origin_i(origin), .temp_sensor_i(16'h012c),
		.temp_housing_i(16'h0131), .switchport_o(switchport_o),
		.sensor_trigger_start_o(trig_o), .exposure_sections_o(sections),
		.rolling_shutter_o(rolling), .calib_ctl_o(calib),
		.column_charge_continuous_o(charge), .profile_init_o(init_cmd),
		.profile_copy_o(copy_cmd));
	cam_link_model u_link (.mclk_i(mclk_i), .fire_i(fire_q), .pix_tick_o(pix_tick),
		.pulse_o(pulse), .cc_o(cc));

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic in_range(input int got, input int lo, input int lim);
		tests_run++;
		if (got < lo || got > lim)
		begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, lim);
		end
	endtask
	task automatic hang();
		check(32'h0, 32'h1);
		give_verdict();
	endtask
	// Idle edge after release, so back-to-back calls never reassign psel
	task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= {idx, 2'b00};
		pwdata_i <= wd;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do
		begin
			@(posedge mclk_i);
			n++;
			if (n > 50)
				hang();
		end
		while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
		apb(1'b1, idx, wd);
	endtask
	task automatic fire(input logic [4:0] f);
		@(posedge mclk_i);
		fire_q <= f;
		@(posedge mclk_i);
		fire_q <= 5'h00;
	endtask
	task automatic measure(input int k, input logic lvl);
		dly = 0;
		wid = 0;
		while (switchport_o[k] !== lvl)
		begin
			@(posedge mclk_i);
			dly++;
			if (dly > 400)
				hang();
		end
		while (switchport_o[k] === lvl)
		begin
			@(posedge mclk_i);
			wid++;
			if (wid > 400)
				hang();
		end
	endtask
	task automatic count(input int sel, input int n);
		hi = 0;
		repeat (n)
		begin
			@(posedge mclk_i);
			hi += int'((sel == 2 ? trig_o : switchport_o[sel]) === 1'b1);
		end
	endtask
	task automatic done(input string s);
		$display("Test %s finished, mismatches so far %0d", s, err_total);
	endtask

	initial
	begin
		repeat (20) @(posedge mclk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		check(32'(switchport_o), 32'h3);
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b0, RIDX[i], 32'h0);
			check(rd, RVAL[i]);
		end
		apb(1'b0, `IDX_EVENT, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, `IDX_TEMP0, 32'h0);
		check(rd, 32'h012c);
		apb(1'b0, 12'h000, 32'h0);
		check({31'h0, err}, 32'h1);
		done("reset and map");
		wr(`IDX_ROI_COL, 32'h64);
		wr(`IDX_ROI_LINE, 32'h96);
		wr(`IDX_ROI_WIDTH, 32'h320);
		wr(`IDX_ROI_HEIGHT, 32'h258);
		apb(1'b0, `IDX_ROI_WIDTH, 32'h0);
		check(rd, 32'h320);
		wr(`IDX_SW1_POLARITY, 32'h0);
		repeat (2) @(posedge mclk_i);
		check(32'(switchport_o[1]), 32'h0);
		done("roi and static level");
		wr(`IDX_SW0_LENGTH, 32'h64);
		wr(`IDX_SW0_SOURCE, 32'h6);
		wr(`IDX_EVENT, 32'h5);
		count(0, 30);
		check(hi, 32'h0);
		wr(`IDX_EVENT, 32'h2);
		measure(0, 1'b1);
		in_range(wid, 19, 25);
		wr(`IDX_SW0_DELAY, 32'hc8);
		wr(`IDX_EVENT, 32'h2);
		measure(0, 1'b1);
		in_range(dly, 38, 48);
		wr(`IDX_SW0_DELAY, 32'h0);
		wr(`IDX_SW0_POLARITY, 32'h0);
		wr(`IDX_EVENT, 32'h2);
		measure(0, 1'b0);
		in_range(wid, 19, 25);
		wr(`IDX_SW0_POLARITY, 32'h1);
		// Switchport 1 is still active low from the static-level test
		wr(`IDX_SW1_DELAY, 32'hc8);
		wr(`IDX_SW1_LENGTH, 32'h64);
		wr(`IDX_SW1_SOURCE, 32'h6);
		wr(`IDX_EVENT, 32'h4);
		measure(1, 1'b0);
		in_range(dly, 38, 48);
		in_range(wid, 19, 25);
		done("software event");
		for (int s = 1; s < 6; s++)
		begin
			wr(`IDX_SW0_SOURCE, 32'(s));
			fire(5'(1 << (s - 1)));
			measure(0, 1'b1);
			in_range(dly, 0, 10);
		end
		wr(`IDX_SHUTTER, 32'h1);
		wr(`IDX_SW0_SOURCE, 32'h2);
		fire(5'h02);
		count(0, 30);
		check(hi, 32'h0);
		check(32'(rolling), 32'h1);
		check(32'(sections), 32'h0);
		wr(`IDX_SHUTTER, 32'h0);
		repeat (2) @(posedge mclk_i);
		check(32'(sections), 32'h1);
		wr(`IDX_EXPOSURE0, 32'hfa0);
		wr(12'h13c, 32'hfa0);
		repeat (2) @(posedge mclk_i);
		check(32'(sections), 32'h3);
		done("sources and shutter");
		for (int m = 0; m < 4; m++)
		begin
			wr(`IDX_CALIB, 32'(m));
			repeat (2) @(posedge mclk_i);
			check(32'(calib), CAL[m]);
		end
		wr(`IDX_CHARGE, 32'h1);
		repeat (2) @(posedge mclk_i);
		check(32'(charge), 32'h1);
		origin <= `TRIG_SRC_EVENT_REG;
		wr(`IDX_EVENT, 32'h1);
		count(2, 6);
		check(hi, 32'h1);
		origin <= 8'h00;
		wr(`IDX_EVENT, 32'h1);
		count(2, 6);
		check(hi, 32'h0);
		wr(`IDX_INIT, 32'h13);
		check(32'(init_cmd), 32'h113);
		wr(`IDX_COPY, 32'h62);
		check(32'(copy_cmd), 32'h162);
		done("sensor control");
		for (int k = 0; k < 8; k++)
			wr(`IDX_LABEL0 + 12'(4 * k), 32'h41424300 + 32'(k));
		for (int k = 0; k < 8; k++)
		begin
			apb(1'b0, `IDX_LABEL0 + 12'(4 * k), 32'h0);
			check(rd, 32'h41424300 + 32'(k));
		end
		nrst_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		nrst_i <= 1'b1;
		@(posedge mclk_i);
		apb(1'b0, `IDX_LABEL0, 32'h0);
		check(rd, 32'h0);
		done("label and volatility");
		give_verdict();
	end
endmodule

/* camera_profile_params.svh */
// Register indices, field positions, reset values and timing constants of
// the camera profile block. Assumes byte address = 4 * index on APB.
`ifndef CAMERA_PROFILE_PARAMS_SVH
`define CAMERA_PROFILE_PARAMS_SVH

`define IDX_PIXEL_RATE      12'h102
`define IDX_SW0_SOURCE      12'h10e
`define IDX_SW0_POLARITY    12'h10f
`define IDX_SW0_DELAY       12'h110
`define IDX_SW0_LENGTH      12'h114
`define IDX_SW1_SOURCE      12'h118
`define IDX_SW1_POLARITY    12'h119
`define IDX_SW1_DELAY       12'h11a
`define IDX_SW1_LENGTH      12'h11e
`define IDX_ROI_COL         12'h130
`define IDX_ROI_LINE        12'h132
`define IDX_ROI_WIDTH       12'h134
`define IDX_ROI_HEIGHT      12'h136
`define IDX_EXPOSURE0       12'h138
`define IDX_EXPOSURE_STEP   12'h004
`define IDX_SHUTTER         12'h148
`define IDX_SKIPPING        12'h149
`define IDX_GAIN            12'h14a
`define IDX_CALIB           12'h14b
`define IDX_CHARGE          12'h14c
`define IDX_LABEL0          12'h150
`define IDX_LABEL_STEP      12'h004
`define IDX_VERSION         12'h900
`define IDX_EVENT           12'h904
`define IDX_INIT            12'h905
`define IDX_COPY            12'h906
`define IDX_TEMP0           12'h908
`define IDX_TEMP1           12'h90a

`define EVT_BIT_TRIGGER     0
`define EVT_BIT_SW0         1
`define EVT_BIT_SW1         2

`define RST_PIXEL_RATE      32'h0262_5a00
`define RST_SW_SOURCE       8'h00
`define RST_SW_POLARITY     8'h01
`define RST_SW_DELAY        32'h0000_0000
`define RST_SW_LENGTH       32'h0000_03e8
`define RST_ROI_COL         16'h0000
`define RST_ROI_LINE        16'h0000
`define RST_ROI_WIDTH       16'h04fe
`define RST_ROI_HEIGHT      16'h03ff
`define RST_EXPOSURE_LOW    32'h0000_0000
`define RST_EXPOSURE_LAST   32'h015e_ef80
`define RST_BYTE_ZERO       8'h00

`define TRIG_SRC_EVENT_REG  8'h04
`define SHUTTER_ROLLING     8'h01
`define CHARGE_CONTINUOUS   8'h01
`define MCLK_PERIOD_NS      32'h0000_0005

`endif

/* camera_profile_pkg.sv */
// Types shared by the camera profile block.
// Assumes the constants header is included by the design files.
package camera_profile_pkg;

	typedef enum logic [7:0] {
		SRC_OFF     = 8'h00,
		SRC_TRIGGER = 8'h01,
		SRC_BEGIN   = 8'h02,
		SRC_END     = 8'h03,
		SRC_CC2     = 8'h04,
		SRC_CC3     = 8'h05,
		SRC_EVENT   = 8'h06
	} sw_source_e;

	typedef enum logic [1:0] {
		SP_IDLE  = 2'b00,
		SP_DELAY = 2'b01,
		SP_PULSE = 2'b10
	} sp_state_e;

	typedef struct packed {
		logic [7:0]  source;
		logic [7:0]  polarity;
		logic [31:0] delay_ns;
		logic [31:0] length_ns;
	} sw_cfg_s;

	typedef struct packed {
		logic fast;
		logic image_start;
		logic line_pending;
	} calib_ctl_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] code;
	} profile_cmd_s;

endpackage
